// File: common/serial_line_pkg.sv
// constants, register layout and carrier types of the serial line format block
// assumes a 16-bit byte address, 32-bit data words and one 250 MHz clock
package serial_line_pkg;
  // register map, byte addresses
  localparam logic [15:0] LFC_CH0_ADDR = 16'hF300;
  localparam logic [15:0] LFC_CH1_ADDR = 16'hF400;
  localparam logic [15:0] TX_DATA_OFS = 16'h0080;
  localparam logic [15:0] RX_DATA_OFS = 16'h0084;
  localparam logic [15:0] STATUS_OFS = 16'h0088;
  // line format control field positions
  localparam int RWAKE_BIT = 15;
  localparam int TWAKE_BIT = 14;
  localparam int OD_BIT = 13;
  localparam int CLK_SRC_LSB = 5;
  localparam int EVEN_BIT = 4;
  localparam int PEN_BIT = 3;
  localparam int STOP2_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int MODE_MULTI_BIT = 1;
  localparam int MODE_SEVEN_BIT = 0;
  // status register bit positions
  localparam int ST_TX_BUSY = 0;
  localparam int ST_TX_SPACE = 1;
  localparam int ST_TX_PENDING = 2;
  localparam int ST_RX_BUSY = 3;
  // transfer clock source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_INT_DIV = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_EXT_DIV = 2'h3;
  localparam int SRC_EXT_BIT = 1;
  localparam int SRC_DIV_BIT = 0;
  // oversampling and bit counts
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] STOP_SECOND = 3'h1;

  typedef struct packed {
    logic rwake;
    logic twake;
    logic od;
    logic [1:0] clk_src;
    logic even;
    logic pen;
    logic stop2;
    logic [1:0] mode;
  } lcr_type;

  localparam lcr_type LCR_RESET = '{twake: 1'b1, default: '0};

  typedef struct packed {
    logic valid;
    logic overrun;
    logic frame_err;
    logic parity_err;
    logic wake;
    logic [7:0] data;
  } rx_word_type;

  // index of the last data bit for a frame mode
  function automatic logic [2:0] last_bit(input logic [1:0] mode);
    return mode[MODE_SEVEN_BIT] ? LAST_BIT_7 : LAST_BIT_8;
  endfunction : last_bit

  // parity bit that makes the frame odd or even
  function automatic logic parity_bit(input logic [7:0] d,
                                      input logic seven, input logic even);
    logic [7:0] m;
    m = seven ? {1'b0, d[6:0]} : d;
    return (^m) ^ ~even;
  endfunction : parity_bit

  // register word to control fields
  function automatic lcr_type lcr_decode(input logic [31:0] w);
    lcr_type l;
    l.rwake = w[RWAKE_BIT];
    l.twake = w[TWAKE_BIT];
    l.od = w[OD_BIT];
    l.clk_src = w[CLK_SRC_LSB +: 2];
    l.even = w[EVEN_BIT];
    l.pen = w[PEN_BIT];
    l.stop2 = w[STOP2_BIT];
    l.mode = w[MODE_LSB +: 2];
    return l;
  endfunction : lcr_decode

  // control fields to register word, reserved bits zero
  function automatic logic [31:0] lcr_word(input lcr_type l);
    logic [31:0] w;
    w = '0;
    w[RWAKE_BIT] = l.rwake;
    w[TWAKE_BIT] = l.twake;
    w[OD_BIT] = l.od;
    w[CLK_SRC_LSB +: 2] = l.clk_src;
    w[EVEN_BIT] = l.even;
    w[PEN_BIT] = l.pen;
    w[STOP2_BIT] = l.stop2;
    w[MODE_LSB +: 2] = l.mode;
    return w;
  endfunction : lcr_word
endpackage : serial_line_pkg

// File: logic/transfer_tick_gen.sv
// transfer clock enable: internal or external source, optionally divided
// assumes ext_clk_i is already synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
module transfer_tick_gen #(
  parameter int DIV = 2
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] clk_src_i,
  input wire logic ext_clk_i,
  output logic tick_o
);
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  typedef struct packed {
    logic ext_prev;
    logic [15:0] div_cnt;
    logic tick;
  } state_type;

  state_type s;
  state_type next_s;
  logic src_edge;
  logic div_hit;

  // pick the source edge, then divide when asked
  always_comb begin
    next_s = s;
    next_s.ext_prev = ext_clk_i;
    src_edge = clk_src_i[serial_line_pkg::SRC_EXT_BIT] ?
               (ext_clk_i && !s.ext_prev) : 1'b1;
    div_hit = src_edge && (s.div_cnt == DIV_LAST);
    if (src_edge) begin
      next_s.div_cnt = div_hit ? '0 : s.div_cnt + 16'h0001;
    end
    next_s.tick = clk_src_i[serial_line_pkg::SRC_DIV_BIT] ? div_hit : src_edge;
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

  // undivided internal source gives a tick on every cycle
  tick_internal_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R05]
    clk_src_i == serial_line_pkg::SRC_INTERNAL |=> tick_o)
    else $error("internal source did not tick every cycle");
endmodule : transfer_tick_gen
`default_nettype wire

// File: logic/byte_fifo.sv
// first-in first-out buffer with valid and ready on both sides
// assumes DEPTH of at least two
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] COUNT_FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } state_type;

  state_type s;
  state_type next_s;
  logic push;
  logic pop;

  // push at the tail, pop at the head, count tracks both
  always_comb begin
    next_s = s;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = (s.wr_ptr == PTR_LAST) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == PTR_LAST) ? '0 : s.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready_o = s.count != COUNT_FULL;
  assign out_valid_o = s.count != '0;
  assign out_data_o = s.mem[s.rd_ptr];

  // refusing input only when every slot is taken
  fifo_full_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !in_ready_o |-> s.count == COUNT_FULL ##1 $stable(s.wr_ptr))
    else $error("fifo refused input while not full");
endmodule : byte_fifo
`default_nettype wire

// File: logic/serial_line_format_control.sv
// serial channel with programmable line format, wake-bit framing and
// a transmit buffer; registers on a plain strobe port
// assumes rxd_i and ext_clk_i are synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R01 - in multi-controller mode a set receive wake select keeps only address frames and a clear one keeps only data frames.
// R02 - in multi-controller mode the transmitter sends the transmit wake value as the frame wake flag.
// R03 - the tx open drain enable makes the transmit pin push-pull when clear and open-drain when set.
// R04 - a slave on a shared multi-controller line sets its transmit pin to open drain.
// R05 - the transfer clock source picks bus clock, divided bus clock, external clock or divided external clock.
// R06 - every line bit lasts sixteen transfer clock ticks.
// R07 - the even parity select picks odd parity when clear and even when set, both ways.
// R08 - the parity check enable turns receive parity checking on or off.
// R09 - software keeps parity checking off in the multi-controller modes.
// R10 - the stop length select sends one stop bit when clear and two when set.
// R11 - the frame format mode picks eight or seven data bits, each plain or multi-controller.
// R12 - outside multi-controller mode the two wake controls change nothing.
// R13 - a received wake flag of one marks an address frame, zero a data frame.
// R14 - an unselected slave with receive wake select still set drops data frames.
// R15 - the wake flag sits right after the last data bit and before the stops.
module serial_line_format_control #(
  parameter logic [15:0] LFC_ADDR = serial_line_pkg::LFC_CH0_ADDR,
  parameter int BAUD_DIV = 2,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rdata_o,
  input wire logic ext_clk_i,
  input wire logic rxd_i,
  output logic txd_out_o,
  output logic txd_oe_n_o,
  output logic tx_ready_o
);
  localparam logic [15:0] TX_ADDR =
    16'(LFC_ADDR + serial_line_pkg::TX_DATA_OFS);
  localparam logic [15:0] RX_ADDR =
    16'(LFC_ADDR + serial_line_pkg::RX_DATA_OFS);
  localparam logic [15:0] ST_ADDR =
    16'(LFC_ADDR + serial_line_pkg::STATUS_OFS);

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP
  } rx_state_type;

  typedef struct packed {
    serial_line_pkg::lcr_type lcr;
    logic [31:0] rdata;
    tx_state_type tx_state;
    logic [3:0] tx_os;
    logic [2:0] tx_idx;
    logic [2:0] tx_last;
    logic [7:0] tx_shift;
    logic tx_has_extra;
    logic tx_extra;
    logic tx_stop2;
    logic txd_out;
    logic txd_oe_n;
    rx_state_type rx_state;
    logic [3:0] rx_os;
    logic [2:0] rx_idx;
    logic [2:0] rx_last;
    logic [7:0] rx_shift;
    logic rx_has_extra;
    logic rx_multi;
    logic rx_rwake;
    logic rx_even;
    logic rx_pen;
    logic rx_seven;
    logic rx_extra;
    serial_line_pkg::rx_word_type rx_word;
  } state_type;

  state_type s;
  state_type next_s;
  logic tick;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic tx_push;
  logic rx_read;
  logic tx_bit_end;
  logic rx_bit_end;
  logic tx_bit;
  logic tx_multi;
  logic rx_done;
  logic rx_store;
  logic rx_par_err;
  logic [7:0] rx_data_now;
  logic [31:0] status_word;

  // transfer clock enable from the selected source
  transfer_tick_gen #(
    .DIV(BAUD_DIV)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clk_src_i(s.lcr.clk_src), // [R05]
    .ext_clk_i(ext_clk_i),
    .tick_o(tick)
  );

  // transmit buffer between the data register and the shifter
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_ready_o),
    .in_data_i(bus_wdata_i[7:0]),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // next state of registers, transmitter and receiver
  always_comb begin
    next_s = s;
    tx_push = bus_wr_i && (bus_addr_i == TX_ADDR);
    rx_read = bus_rd_i && (bus_addr_i == RX_ADDR);
    tx_multi = s.lcr.mode[serial_line_pkg::MODE_MULTI_BIT];

    // register writes
    if (bus_wr_i && (bus_addr_i == LFC_ADDR)) begin
      next_s.lcr = serial_line_pkg::lcr_decode(bus_wdata_i);
    end

    // read data stands for one cycle only, zero elsewhere
    status_word = '0;
    status_word[serial_line_pkg::ST_TX_BUSY] = s.tx_state != TX_IDLE;
    status_word[serial_line_pkg::ST_TX_SPACE] = tx_ready_o;
    status_word[serial_line_pkg::ST_TX_PENDING] = fifo_valid;
    status_word[serial_line_pkg::ST_RX_BUSY] = s.rx_state != RX_IDLE;
    next_s.rdata = '0;
    if (bus_rd_i) begin
      if (bus_addr_i == LFC_ADDR) begin
        next_s.rdata = serial_line_pkg::lcr_word(s.lcr);
      end else if (bus_addr_i == RX_ADDR) begin
        next_s.rdata = 32'(s.rx_word);
      end else if (bus_addr_i == ST_ADDR) begin
        next_s.rdata = status_word;
      end
    end

    // transmitter: sixteen ticks per bit
    fifo_pop = 1'b0;
    if (s.tx_state != TX_IDLE && tick) begin
      next_s.tx_os = s.tx_os + 4'h1; // [R06]
    end
    tx_bit_end = tick && (s.tx_os == serial_line_pkg::OS_LAST); // [R06]
    case (s.tx_state)
      TX_IDLE: begin
        if (tick && fifo_valid) begin
          fifo_pop = 1'b1;
          next_s.tx_state = TX_START;
          next_s.tx_shift = fifo_data;
          next_s.tx_idx = '0;
          next_s.tx_last = serial_line_pkg::last_bit(s.lcr.mode); // [R11]
          next_s.tx_stop2 = s.lcr.stop2; // [R10]
          // wake flag replaces parity; wake value ignored otherwise
          next_s.tx_has_extra = tx_multi || s.lcr.pen; // [R12] [R09]
          next_s.tx_extra = tx_multi ? s.lcr.twake : // [R02]
            serial_line_pkg::parity_bit(fifo_data,
              s.lcr.mode[serial_line_pkg::MODE_SEVEN_BIT],
              s.lcr.even); // [R07]
        end
      end
      TX_START: begin
        if (tx_bit_end) begin
          next_s.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_bit_end) begin
          next_s.tx_shift = s.tx_shift >> 1;
          next_s.tx_idx = s.tx_idx + 3'h1;
          if (s.tx_idx == s.tx_last) begin // [R11]
            next_s.tx_idx = '0;
            next_s.tx_state = s.tx_has_extra ? TX_EXTRA : TX_STOP; // [R15]
          end
        end
      end
      TX_EXTRA: begin
        if (tx_bit_end) begin
          next_s.tx_state = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_bit_end) begin
          next_s.tx_idx = s.tx_idx + 3'h1;
          if (!s.tx_stop2 || (s.tx_idx == serial_line_pkg::STOP_SECOND)) begin
            next_s.tx_state = TX_IDLE; // [R10]
          end
        end
      end
      default: next_s.tx_state = TX_IDLE;
    endcase

    // line level of the next bit, then the pin drive type
    tx_bit = 1'b1;
    if (next_s.tx_state == TX_START) begin
      tx_bit = 1'b0;
    end else if (next_s.tx_state == TX_DATA) begin
      tx_bit = next_s.tx_shift[0];
    end else if (next_s.tx_state == TX_EXTRA) begin
      tx_bit = next_s.tx_extra;
    end
    next_s.txd_out = s.lcr.od ? 1'b0 : tx_bit; // [R03]
    next_s.txd_oe_n = s.lcr.od ? tx_bit : 1'b0; // [R03]

    // receiver: start found low, sampled at mid start, then every 16
    rx_done = 1'b0;
    if (s.rx_state != RX_IDLE && tick) begin
      next_s.rx_os = s.rx_os + 4'h1; // [R06]
    end
    rx_bit_end = tick && (s.rx_os == serial_line_pkg::OS_LAST); // [R06]
    case (s.rx_state)
      RX_IDLE: begin
        if (tick && !rxd_i) begin
          next_s.rx_state = RX_START;
          next_s.rx_idx = '0;
          next_s.rx_last = serial_line_pkg::last_bit(s.lcr.mode); // [R11]
          next_s.rx_seven = s.lcr.mode[serial_line_pkg::MODE_SEVEN_BIT];
          next_s.rx_multi = tx_multi;
          next_s.rx_has_extra = tx_multi || s.lcr.pen; // [R15]
          next_s.rx_rwake = s.lcr.rwake;
          next_s.rx_even = s.lcr.even; // [R07]
          next_s.rx_pen = s.lcr.pen; // [R08]
        end
      end
      RX_START: begin
        if (tick && (s.rx_os == serial_line_pkg::OS_MID)) begin
          next_s.rx_os = '0;
          next_s.rx_state = rxd_i ? RX_IDLE : RX_DATA; // glitch rejected
        end
      end
      RX_DATA: begin
        if (rx_bit_end) begin
          next_s.rx_shift = {rxd_i, s.rx_shift[7:1]};
          next_s.rx_idx = s.rx_idx + 3'h1;
          if (s.rx_idx == s.rx_last) begin
            next_s.rx_state = s.rx_has_extra ? RX_EXTRA : RX_STOP; // [R15]
          end
        end
      end
      RX_EXTRA: begin
        if (rx_bit_end) begin
          next_s.rx_extra = rxd_i;
          next_s.rx_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_bit_end) begin
          rx_done = 1'b1;
          next_s.rx_state = RX_IDLE;
        end
      end
      default: next_s.rx_state = RX_IDLE;
    endcase

    // frame check and wake filter
    rx_data_now = s.rx_seven ? {1'b0, s.rx_shift[7:1]} : s.rx_shift;
    rx_par_err = s.rx_pen && !s.rx_multi && (s.rx_extra != // [R08]
      serial_line_pkg::parity_bit(rx_data_now, s.rx_seven, s.rx_even));
    rx_store = rx_done &&
      (!s.rx_multi || (s.rx_extra == s.rx_rwake)); // [R01] [R14] [R12]

    // reading the receive word empties it; a new frame wins
    if (rx_read) begin
      next_s.rx_word.valid = 1'b0;
      next_s.rx_word.overrun = 1'b0;
    end
    if (rx_store) begin
      next_s.rx_word.valid = 1'b1;
      next_s.rx_word.overrun = s.rx_word.valid && !rx_read;
      next_s.rx_word.frame_err = !rxd_i;
      next_s.rx_word.parity_err = rx_par_err;
      next_s.rx_word.wake = s.rx_multi && s.rx_extra; // [R13]
      next_s.rx_word.data = rx_data_now;
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.lcr <= serial_line_pkg::LCR_RESET;
      s.txd_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus_rdata_o = s.rdata;
  assign txd_out_o = s.txd_out;
  assign txd_oe_n_o = s.txd_oe_n;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // kept frames in multi mode carry the wake flag that was selected
  wake_filter_a: assert property (rx_done && s.rx_multi && // [R01]
    s.rx_extra == s.rx_rwake |=> s.rx_word.valid &&
    s.rx_word.wake == $past(s.rx_rwake))
    else $error("selected multi-controller frame not kept");

  // data frames reach no unselected slave
  drop_data_a: assert property (rx_done && s.rx_multi && s.rx_rwake && // [R14]
    !s.rx_extra |=> $stable(s.rx_word.data) || !s.rx_word.valid)
    else $error("data frame kept while wake select set");

  // the wake value is loaded as the frame flag in multi mode
  tx_wake_a: assert property (fifo_pop && tx_multi |=> // [R02]
    s.tx_has_extra && s.tx_extra == $past(s.lcr.twake))
    else $error("transmit wake flag not taken from control");

  // pin drive type follows the open drain enable
  open_drain_a: assert property (s.lcr.od |=> !txd_out_o) // [R03]
    else $error("open drain pin driven high");
  push_pull_a: assert property (!s.lcr.od |=> !txd_oe_n_o) // [R03]
    else $error("push-pull pin released");

  // no bit of a frame ends before sixteen ticks
  tx_bit_time_a: assert property (s.tx_state != TX_IDLE && // [R06]
    next_s.tx_state != s.tx_state |-> tick &&
    s.tx_os == serial_line_pkg::OS_LAST)
    else $error("transmit bit not sixteen ticks long");

  // parity generated with the selected sense
  tx_parity_a: assert property (fifo_pop && !tx_multi && s.lcr.pen |=> // [R07]
    s.tx_extra == serial_line_pkg::parity_bit($past(fifo_data),
      $past(s.lcr.mode[0]), $past(s.lcr.even)))
    else $error("transmit parity wrong sense");

  // no parity error without checking enabled
  rx_parity_off_a: assert property (rx_store && !s.rx_pen |=> // [R08]
    !s.rx_word.parity_err)
    else $error("parity error flagged with checking off");

  // a second stop bit only when two are selected
  stop_len_a: assert property (s.tx_state == TX_STOP && s.tx_idx == 3'h1 // [R10]
    |-> s.tx_stop2)
    else $error("second stop bit sent with one selected");

  // seven-bit frames never reach the eighth data bit
  data_len_a: assert property (fifo_pop |=> s.tx_last == // [R11]
    ($past(s.lcr.mode[serial_line_pkg::MODE_SEVEN_BIT]) ?
      serial_line_pkg::LAST_BIT_7 : serial_line_pkg::LAST_BIT_8))
    else $error("data length not from frame mode");

  // the wake or parity slot follows the last data bit directly
  wake_slot_a: assert property (s.tx_state == TX_DATA && tx_bit_end && // [R15]
    s.tx_idx == s.tx_last && s.tx_has_extra |=> s.tx_state == TX_EXTRA)
    else $error("wake slot not after last data bit");
endmodule : serial_line_format_control
`default_nettype wire

// File: dv/remote_serial_model.sv
// remote serial controller on the shared line: captures and sends frames
// assumes a line synchronous to clk_i, bits of p or 16 clock cycles
`timescale 1ns/100ps
`default_nettype none
module remote_serial_model (
  input wire logic clk_i,
  input wire logic line_i,
  output logic rxd_o
);
  // push-pull output: driven low or driven high, high when idle
  initial rxd_o = 1'b1;

  // send n bits lsb first, start bit in f[0], then release the line
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i] ? 1'b1 : 1'b0;
      repeat (16) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send

  // wait for a start bit, then sample n bits mid-bit at period p
  task automatic grab(output logic [11:0] f, input int n, input int p);
    int k;
    f = '0;
    k = 0;
    while (line_i !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (p / 2) @(posedge clk_i);
    f[0] = line_i;
    for (int i = 1; i < n; i++) begin
      repeat (p) @(posedge clk_i);
      f[i] = line_i;
    end
  endtask : grab
endmodule : remote_serial_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the serial line format block
// assumes the remote model on the line and a 250 MHz core clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  localparam logic [15:0] A = serial_line_pkg::LFC_CH0_ADDR;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b0;
  logic rxd, txd, oe_n, rdy;
  logic [31:0] rdata, q;
  logic [11:0] f;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  // core clock, 4 ns period
  always #2 core_clk_i = ~core_clk_i;

  serial_line_format_control #(.BAUD_DIV(1)) uut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_rdata_o(rdata), .ext_clk_i(ext_clk), .rxd_i(rxd),
    .txd_out_o(txd), .txd_oe_n_o(oe_n), .tx_ready_o(rdy));

  // line level: released pin reads high through the pull-up
  remote_serial_model far (.clk_i(core_clk_i), .line_i(oe_n | txd),
    .rxd_o(rxd));

  // external clock, one rising edge every two core cycles when running
  always @(posedge core_clk_i) begin
    if (ext_run) ext_clk <= ~ext_clk;
  end

  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 q = rdata;
    `CHK(q, e)
  endtask : chk_reg

  // program the format, send one byte, capture n line bits
  task automatic tx(input logic [31:0] l, input logic [7:0] d, input int n,
                    input int p, input logic [11:0] e);
    wr_reg(A, l);
    wr_reg(A + 16'h0080, {24'h0, d});
    far.grab(f, n, p);
    `CHK(f, e)
  endtask : tx

  // program the format, receive one frame, read the rx word
  task automatic rx(input logic [31:0] l, input logic [11:0] fr,
                    input int n, input logic [31:0] e);
    wr_reg(A, l);
    far.send(fr, n);
    repeat (4) @(posedge core_clk_i);
    chk_reg(A + 16'h0084, e);
  endtask : rx

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    chk_reg(A, 32'h00004000);
    chk_reg(A + 16'h0004, 32'h0);
    wr_reg(A, 32'hFFFFFFFF);
    chk_reg(A, 32'h0000E07F);
    tx(32'h4000, 8'hA5, 10, 16, {3'b001, 8'hA5, 1'b0});
    `CHK(oe_n, 1'b0)
    tx(32'h1D, 8'h5B, 11, 16, {3'b111, 7'h5B, 1'b0});
    chk_reg(A + 16'h0088, 32'h3);
    tx(32'h28, 8'h5B, 11, 16, {2'b10, 8'h5B, 1'b0});
    tx(32'h6002, 8'h3C, 11, 16, {2'b11, 8'h3C, 1'b0});
    `CHK(oe_n, 1'b1)
    tx(32'h0003, 8'hC1, 10, 16, {2'b10, 7'h41, 1'b0});
    ext_run <= 1'b1;
    tx(32'h60, 8'hC3, 10, 32, {3'b001, 8'hC3, 1'b0});
    ext_run <= 1'b0;
    // multi modes keep parity checking off
    rx(32'h8002, {2'b11, 8'h12, 1'b0}, 11, 32'h1112);
    rx(32'h8002, {2'b10, 8'h34, 1'b0}, 11, 32'h112);
    rx(32'h0002, {2'b10, 8'h34, 1'b0}, 11, 32'h1034);
    rx(32'h0002, {2'b11, 8'h56, 1'b0}, 11, 32'h34);
    rx(32'h08, {2'b11, 8'h5B, 1'b0}, 11, 32'h125B);
    rx(32'h18, {2'b11, 8'h5B, 1'b0}, 11, 32'h105B);
    rx(32'h8000, {3'b001, 8'h77, 1'b0}, 10, 32'h1077);
    // external source with no edges stalls the sender: fill past full
    wr_reg(A, 32'h40);
    for (int i = 0; i < 9; i++) wr_reg(A + 16'h0080, 32'(i));
    `CHK(rdy, 1'b0)
    wr_reg(A, 32'h0);
    for (int i = 0; i < 8; i++) begin
      far.grab(f, 10, 16);
      `CHK(f, {3'b001, 8'(i), 1'b0})
    end
    repeat (200) @(posedge core_clk_i);
    chk_reg(A + 16'h0088, 32'h2);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
